// ==== rtl/lcfg_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef LCFG_DEFS_SVH
`define LCFG_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LCFG_ADDR_PORT_DIR   16'hFF26
`define LCFG_ADDR_PORT_OM    16'hFF2A
`define LCFG_ADDR_PORT_IBS   16'hFF3E
`define LCFG_ADDR_CTL_TWO    16'hFFA8
`define LCFG_ADDR_CLK_LOW    16'hFFAA
`define LCFG_ADDR_CLK_HIGH   16'hFFAB

// ****************************************************************
// Reset values
// ****************************************************************
`define LCFG_RST_PORT_DIR    8'hFF
`define LCFG_RST_PORT_OM     8'h00
`define LCFG_RST_PORT_IBS    8'h00
`define LCFG_RST_CTL_TWO     8'h00
`define LCFG_RST_WIDTH       8'hFF

// ****************************************************************
// Field positions of the second control register
// ****************************************************************
`define LCFG_CTL_WAKEUP      7
`define LCFG_CTL_CLK_LVL     5
`define LCFG_CTL_DAT_LVL     4
`define LCFG_CTL_SPEED       3
`define LCFG_CTL_FILTER      2

// Writable bits of the control and port registers; the width registers take all bits
`define LCFG_MASK_CTL_TWO    8'h8C
`define LCFG_MASK_PORT_DIR   8'h0F
`define LCFG_MASK_PORT_OM    8'h0F
`define LCFG_MASK_PORT_IBS   8'h03

// ****************************************************************
// Timing counts
// ****************************************************************
`define LCFG_FILTER_LEN      3

`endif

// ==== rtl/lcfg_pkg.sv ====
// Types shared by the line configuration block
package lcfg_pkg;

	typedef enum logic [2:0] {
		LCFG_GEN_IDLE = 3'b001,
		LCFG_GEN_LOW  = 3'b010,
		LCFG_GEN_HIGH = 3'b100
	} lcfg_gen_state_t;

endpackage

// ==== rtl/lcfg_filter.sv ====
// Digital noise filter for one sampled bus line
`timescale 1ns/1ps
`include "lcfg_defs.svh"

module lcfg_filter
	import lcfg_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	input  wire logic bypass_i,
	input  wire logic line_i,
	output logic      line_o
);

	logic [`LCFG_FILTER_LEN-1:0] hist_q;
	logic                        line_q;
	wire                         all_high;
	wire                         all_low;

	// With bypass_i low, a level only passes after it has been seen on every recent sample
	assign all_high = &hist_q;
	assign all_low  = ~|hist_q;

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			hist_q <= '1;
		end else begin
			hist_q <= {hist_q[`LCFG_FILTER_LEN-2:0], line_i};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			line_q <= 1'b1;
		end else if (bypass_i) begin
			line_q <= line_i;
		end else if (all_high) begin
			line_q <= 1'b1;
		end else if (all_low) begin
			line_q <= 1'b0;
		end
	end

	assign line_o = line_q;

endmodule // lcfg_filter

// ==== rtl/lcfg_top.sv ====
// Line level status, speed and filter control, clock widths, pin setup
// Behaviour
// - Clock level bit reads pin high as 1; low or disabled reads 0.
// - Data level bit reads pin high as 1; low or disabled reads 0.
// - Level bits at positions 4 and 5 are read-only.
// - Speed bit 0 selects standard mode, 1 selects fast mode.
// - Filter bit 0 turns the noise filter off, 1 turns it on in fast mode only.
// - Fast mode clock frequency does not depend on the filter.
// - Low-width register sets master clock low time; resets to FFH.
// - High-width register sets master clock high time; resets to FFH.
// - Buffer select bit: 0 Schmitt input, 1 SMBus input levels.
// - Output mode bit: 0 push-pull, 1 open-drain.
// - Reset clears buffer select and output mode registers to 00H.
// - Direction bit 0 enables output, 1 input only; resets FFH.
// - Reset clears the second control register to 00H.
`timescale 1ns/1ps
`include "lcfg_defs.svh"

module lcfg_top
	import lcfg_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        controller_enable_i,
	input  wire logic        master_clk_run_i,
	input  wire logic        scl_drive_low_i,
	input  wire logic        sda_drive_low_i,
	input  wire logic        clock_port_pin_i,
	input  wire logic        data_port_pin_i,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_o,
	input  wire logic        serial_data_pin_i,
	output logic             serial_data_pin_o,
	output logic             serial_data_pin_oe_o,
	output logic             clock_pin_buffer_select_o,
	output logic             data_pin_buffer_select_o,
	output logic             scl_filtered_o,
	output logic             sda_filtered_o,
	output logic             speed_mode_select_o,
	output logic             address_wakeup_enable_o,
	output logic             master_clk_low_o
);

	default clocking lcfg_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ****************************************************************
	// Register bus decode
	// ****************************************************************
	function automatic logic addr_hit(input logic [15:0] a,
	                                  input logic [15:0] off);
		addr_hit = (a == off);
	endfunction

	logic [7:0] port_direction_q;
	logic [7:0] port_output_mode_q;
	logic [7:0] port_input_buffer_select_q;
	logic [7:0] serial_control_two_q;
	logic [7:0] clock_low_width_q;
	logic [7:0] clock_high_width_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	wire        wr_dir   = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_PORT_DIR);
	wire        wr_om    = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_PORT_OM);
	wire        wr_ibs   = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_PORT_IBS);
	wire        wr_ctl   = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_CTL_TWO);
	wire        wr_low   = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_CLK_LOW);
	wire        wr_high  = reg_wr_i & addr_hit(reg_addr_i, `LCFG_ADDR_CLK_HIGH);

	// ****************************************************************
	// Pin synchronisers and noise filters
	// ****************************************************************
	wire  [1:0] pin_raw = {serial_data_pin_i, serial_clock_pin_i};
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	wire  [1:0] filt;
	wire        fast_mode  = serial_control_two_q[`LCFG_CTL_SPEED];
	// Filter only acts in fast mode; standard mode bypasses it
	wire        filt_bypass = ~(fast_mode &
	                          serial_control_two_q[`LCFG_CTL_FILTER]);

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			sync1_q <= 2'h3;
			sync2_q <= 2'h3;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	for (genvar gi = 0; gi < 2; gi++) begin : g_filt
		lcfg_filter u_lcfg_filter (
			.sys_clk_i (sys_clk_i),
			.resetn_i  (resetn_i),
			.bypass_i  (filt_bypass),
			.line_i    (sync2_q[gi]),
			.line_o    (filt[gi])
		);
	end

	assign scl_filtered_o = filt[0];
	assign sda_filtered_o = filt[1];

	// Level bits read zero whenever the controller is stopped
	wire clk_level = controller_enable_i & filt[0];
	wire dat_level = controller_enable_i & filt[1];

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			port_direction_q           <= `LCFG_RST_PORT_DIR;
			port_output_mode_q         <= `LCFG_RST_PORT_OM;
			port_input_buffer_select_q <= `LCFG_RST_PORT_IBS;
			serial_control_two_q       <= `LCFG_RST_CTL_TWO;
			clock_low_width_q          <= `LCFG_RST_WIDTH;
			clock_high_width_q         <= `LCFG_RST_WIDTH;
		end else begin
			if (wr_dir) begin
				port_direction_q <= reg_wdata_i | ~`LCFG_MASK_PORT_DIR;
			end
			if (wr_om) begin
				port_output_mode_q <= reg_wdata_i & `LCFG_MASK_PORT_OM;
			end
			if (wr_ibs) begin
				port_input_buffer_select_q <= reg_wdata_i & `LCFG_MASK_PORT_IBS;
			end
			if (wr_ctl) begin
				// Level bits are never stored
				serial_control_two_q <= reg_wdata_i & `LCFG_MASK_CTL_TWO;
			end
			if (wr_low) begin
				clock_low_width_q <= reg_wdata_i;
			end
			if (wr_high) begin
				clock_high_width_q <= reg_wdata_i;
			end
		end
	end

	wire [7:0] ctl_rd = serial_control_two_q |
	                    {2'h0, clk_level, dat_level, 4'h0};

	always_comb begin
		case (reg_addr_i)
			`LCFG_ADDR_PORT_DIR: rdata_d = port_direction_q;
			`LCFG_ADDR_PORT_OM:  rdata_d = port_output_mode_q;
			`LCFG_ADDR_PORT_IBS: rdata_d = port_input_buffer_select_q;
			`LCFG_ADDR_CTL_TWO:  rdata_d = ctl_rd;
			`LCFG_ADDR_CLK_LOW:  rdata_d = clock_low_width_q;
			`LCFG_ADDR_CLK_HIGH: rdata_d = clock_high_width_q;
			default:             rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o             = rdata_q;
	assign speed_mode_select_o     = fast_mode;
	assign address_wakeup_enable_o = serial_control_two_q[`LCFG_CTL_WAKEUP];
	assign clock_pin_buffer_select_o = port_input_buffer_select_q[0];
	assign data_pin_buffer_select_o  = port_input_buffer_select_q[1];

	// ****************************************************************
	// Master clock width generator
	// ****************************************************************
	// Counts only the width registers, never the filtered line, so the
	// filter setting cannot shift the generated frequency.
	lcfg_gen_state_t gen_q;
	lcfg_gen_state_t gen_d;
	logic [7:0]      cnt_q;
	logic [7:0]      cnt_d;
	wire             gen_run  = controller_enable_i & master_clk_run_i;
	wire             cnt_last = (cnt_q <= 8'h01);

	always_comb begin
		gen_d = gen_q;
		cnt_d = cnt_q - 8'h01;
		case (gen_q)
			LCFG_GEN_IDLE: begin
				cnt_d = clock_low_width_q;
				if (gen_run) begin
					gen_d = LCFG_GEN_LOW;
				end
			end
			LCFG_GEN_LOW: begin
				if (cnt_last) begin
					gen_d = LCFG_GEN_HIGH;
					cnt_d = clock_high_width_q;
				end
			end
			LCFG_GEN_HIGH: begin
				if (cnt_last) begin
					gen_d = LCFG_GEN_LOW;
					cnt_d = clock_low_width_q;
				end
			end
			default: begin
				gen_d = LCFG_GEN_IDLE;
				cnt_d = clock_low_width_q;
			end
		endcase
		if (!gen_run) begin
			gen_d = LCFG_GEN_IDLE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			gen_q <= LCFG_GEN_IDLE;
			cnt_q <= 8'h00;
		end else begin
			gen_q <= gen_d;
			cnt_q <= cnt_d;
		end
	end

	assign master_clk_low_o = (gen_q == LCFG_GEN_LOW);

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	logic scl_out_q;
	logic scl_oe_q;
	logic sda_out_q;
	logic sda_oe_q;

	wire scl_val = clock_port_pin_i & ~master_clk_low_o & ~scl_drive_low_i;
	wire sda_val = data_port_pin_i & ~sda_drive_low_i;
	// Open-drain drives only the low level; push-pull drives both
	wire scl_en  = ~port_direction_q[0] &
	               (~port_output_mode_q[0] | ~scl_val);
	wire sda_en  = ~port_direction_q[1] &
	               (~port_output_mode_q[1] | ~sda_val);

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			scl_out_q <= 1'b1;
			scl_oe_q  <= 1'b0;
			sda_out_q <= 1'b1;
			sda_oe_q  <= 1'b0;
		end else begin
			scl_out_q <= scl_val;
			scl_oe_q  <= scl_en;
			sda_out_q <= sda_val;
			sda_oe_q  <= sda_en;
		end
	end

	assign serial_clock_pin_o    = scl_out_q;
	assign serial_clock_pin_oe_o = scl_oe_q;
	assign serial_data_pin_o     = sda_out_q;
	assign serial_data_pin_oe_o  = sda_oe_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [8:0] run_cnt_q;
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || gen_q != gen_d) begin
			run_cnt_q <= 9'h001;
		end else begin
			run_cnt_q <= run_cnt_q + 9'h001;
		end
	end

	// Bypassed line: the level bit follows the synchronised pin one later
	a_clk_level: assert property (
		$past(filt_bypass) |-> ctl_rd[`LCFG_CTL_CLK_LVL] ==
		(controller_enable_i & $past(sync2_q[0])))
		else $error("clock level bit wrong");
	a_dat_level: assert property (
		!controller_enable_i |-> !ctl_rd[`LCFG_CTL_DAT_LVL])
		else $error("data level bit set while disabled");
	a_level_ro: assert property (
		wr_ctl |=> serial_control_two_q[5:4] == 2'h0)
		else $error("level bits stored by a write");
	a_speed_out: assert property (
		wr_ctl |=> speed_mode_select_o == $past(reg_wdata_i[`LCFG_CTL_SPEED]))
		else $error("speed select not taken");
	a_filter_hold: assert property (
		$past(!filt_bypass) && $changed(filt[0]) |->
		$past(sync2_q[0], 2) == filt[0] && $past(sync2_q[0], 3) == filt[0]
		&& $past(sync2_q[0], 4) == filt[0])
		else $error("filter passed a short glitch");
	a_filter_skip: assert property (
		!fast_mode |=> filt[1] == $past(sync2_q[1]))
		else $error("filter active in standard mode");
	a_low_width: assert property (
		gen_q == LCFG_GEN_LOW && gen_d == LCFG_GEN_HIGH && !wr_low
		|-> run_cnt_q == ((clock_low_width_q == 8'h00) ? 9'h001
		                 : {1'b0, clock_low_width_q}))
		else $error("clock low width wrong");
	a_high_width: assert property (
		gen_q == LCFG_GEN_HIGH && gen_d == LCFG_GEN_LOW && !wr_high
		|-> run_cnt_q == ((clock_high_width_q == 8'h00) ? 9'h001
		                 : {1'b0, clock_high_width_q}))
		else $error("clock high width wrong");
	a_open_drain: assert property (
		$past(port_output_mode_q[0]) && serial_clock_pin_oe_o
		|-> !serial_clock_pin_o)
		else $error("open-drain pin drove high");
	a_dir_input: assert property (
		port_direction_q[1] |=> !serial_data_pin_oe_o)
		else $error("input-only pin driven");
	a_port_reset: assert property (
		$past(!resetn_i) |-> port_output_mode_q == 8'h00
		&& port_input_buffer_select_q == 8'h00)
		else $error("port mode registers not cleared");
	a_ctl_reset: assert property (
		$past(!resetn_i) |-> serial_control_two_q == 8'h00
		&& clock_low_width_q == 8'hFF && port_direction_q == 8'hFF)
		else $error("reset values wrong");

endmodule // lcfg_top

// ==== dv/lcfg_bus_peer.sv ====
// Model of the other devices that share the two open-drain bus lines
`timescale 1ns/1ps

module lcfg_bus_peer (
	input  wire logic sys_clk_i,
	input  wire logic scl_val_i,
	input  wire logic scl_oe_i,
	input  wire logic sda_val_i,
	input  wire logic sda_oe_i,
	output logic      scl_line_o,
	output logic      sda_line_o
);
	logic scl_hold_q = 1'b0;
	logic sda_hold_q = 1'b0;

	// ****************************************************************
	// Wired-AND lines with pull-ups
	// ****************************************************************
	// A released line reads high; any low driver wins
	assign scl_line_o = (scl_oe_i ? scl_val_i : 1'b1) & ~scl_hold_q;
	assign sda_line_o = (sda_oe_i ? sda_val_i : 1'b1) & ~sda_hold_q;

	task automatic sda_pulse(input int cycles);
		@(posedge sys_clk_i);
		sda_hold_q <= 1'b1;
		repeat (cycles) @(posedge sys_clk_i);
		sda_hold_q <= 1'b0;
	endtask

	task automatic hold(input logic scl, input logic sda);
		@(posedge sys_clk_i);
		scl_hold_q <= scl;
		sda_hold_q <= sda;
	endtask

	// 200 ns link clock inside the burst only; offset keeps it off the
	// system clock edges
	task automatic clock_burst(input int pulses);
		#7;
		repeat (pulses) begin
			#100 scl_hold_q <= 1'b1;
			#100 scl_hold_q <= 1'b0;
		end
	endtask
endmodule // lcfg_bus_peer

// ==== dv/test_lcfg_top.sv ====
// Self-checking testbench of the line configuration block
`timescale 1ns/1ps
`include "lcfg_defs.svh"

module test_lcfg_top;
	logic        clk   = 1'b0;
	logic        rstn  = 1'b0;
	logic [15:0] addr  = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr_s  = 1'b0;
	logic        rd_s  = 1'b0;
	logic        en    = 1'b0;
	logic        run   = 1'b0;
	logic        scl_dl = 1'b0;
	logic        sda_dl = 1'b0;
	logic [7:0]  rdata;
	logic        scl_o, scl_oe, sda_o, sda_oe, scl_ln, sda_ln;
	logic        cbs, dbs, sclf, sdaf, spd, address_wakeup_enable, mlow;
	int          failures = 0;
	int          cmp_count = 0;
	int          lo, hi, n;
	logic        seen, prev;
	logic [7:0]  fcfg [4] = '{8'h08, 8'h0C, 8'h0C, 8'h04};
	int          flen [4] = '{2, 2, 4, 2};
	logic [7:0]  fexp [4] = '{8'h01, 8'h00, 8'h01, 8'h01};

	always #12.5 clk = ~clk;

	lcfg_top u_lcfg_top (
		.sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdata), .controller_enable_i(en),
		.master_clk_run_i(run), .scl_drive_low_i(scl_dl),
		.sda_drive_low_i(sda_dl), .clock_port_pin_i(1'b1),
		.data_port_pin_i(1'b1), .serial_clock_pin_i(scl_ln),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe),
		.serial_data_pin_i(sda_ln), .serial_data_pin_o(sda_o),
		.serial_data_pin_oe_o(sda_oe), .clock_pin_buffer_select_o(cbs),
		.data_pin_buffer_select_o(dbs), .scl_filtered_o(sclf),
		.sda_filtered_o(sdaf), .speed_mode_select_o(spd),
		.address_wakeup_enable_o(address_wakeup_enable), .master_clk_low_o(mlow)
	);

	lcfg_bus_peer u_lcfg_bus_peer (
		.sys_clk_i(clk), .scl_val_i(scl_o), .scl_oe_i(scl_oe),
		.sda_val_i(sda_o), .sda_oe_i(sda_oe),
		.scl_line_o(scl_ln), .sda_line_o(sda_ln)
	);

	// ****************************************************************
	// Access and compare tasks
	// ****************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		#1;
		chk(rdata, e);
	endtask

	// Mode changes only with the controller stopped
	task automatic set_ctl(input logic [7:0] d);
		@(posedge clk);
		en <= 1'b0;
		wr(`LCFG_ADDR_CTL_TWO, d);
		@(posedge clk);
		en <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic stop_test();
		$display("comparisons=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		stop_test();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(`LCFG_ADDR_PORT_DIR, 8'hFF);
		rd(`LCFG_ADDR_PORT_OM, 8'h00);
		rd(`LCFG_ADDR_PORT_IBS, 8'h00);
		rd(`LCFG_ADDR_CTL_TWO, 8'h00);
		rd(`LCFG_ADDR_CLK_LOW, 8'hFF);
		rd(`LCFG_ADDR_CLK_HIGH, 8'hFF);
		rd(16'hFF00, 8'h00);
		wr(`LCFG_ADDR_PORT_IBS, 8'h01);
		step();
		chk({6'h00, dbs, cbs}, 8'h01);
		wr(`LCFG_ADDR_PORT_IBS, 8'hFF);
		rd(`LCFG_ADDR_PORT_IBS, 8'h03);
		chk({6'h00, dbs, cbs}, 8'h03);
		wr(`LCFG_ADDR_PORT_OM, 8'hFF);
		rd(`LCFG_ADDR_PORT_OM, 8'h0F);
		wr(`LCFG_ADDR_PORT_DIR, 8'h00);
		rd(`LCFG_ADDR_PORT_DIR, 8'hF0);
		// Level bits ignore writes and read 0 while stopped
		wr(`LCFG_ADDR_CTL_TWO, 8'hFF);
		rd(`LCFG_ADDR_CTL_TWO, 8'h8C);
		chk({6'h00, address_wakeup_enable, spd}, 8'h03);
		set_ctl(8'h08);
		rd(`LCFG_ADDR_CTL_TWO, 8'h38);
		chk({7'h00, spd}, 8'h01);
		@(posedge clk);
		scl_dl <= 1'b1;
		sda_dl <= 1'b1;
		repeat (5) @(posedge clk);
		rd(`LCFG_ADDR_CTL_TWO, 8'h08);
		chk({6'h00, scl_oe, sda_oe}, 8'h03);
		@(posedge clk);
		scl_dl <= 1'b0;
		sda_dl <= 1'b0;
		u_lcfg_bus_peer.hold(1'b0, 1'b1);
		repeat (5) @(posedge clk);
		rd(`LCFG_ADDR_CTL_TWO, 8'h28);
		u_lcfg_bus_peer.hold(1'b1, 1'b0);
		repeat (5) @(posedge clk);
		rd(`LCFG_ADDR_CTL_TWO, 8'h18);
		u_lcfg_bus_peer.hold(1'b0, 1'b0);
		// Short low pulses against each filter setting
		for (int i = 0; i < 4; i++) begin
			set_ctl(fcfg[i]);
			seen = 1'b0;
			fork
				u_lcfg_bus_peer.sda_pulse(flen[i]);
				repeat (12) begin
					step();
					if (sdaf === 1'b0)
						seen = 1'b1;
				end
			join
			chk({7'h00, seen}, fexp[i]);
		end
		// Link clock burst seen through the synchroniser
		set_ctl(8'h08);
		n = 0;
		prev = 1'b1;
		fork
			u_lcfg_bus_peer.clock_burst(5);
			repeat (52) begin
				step();
				if (sclf === 1'b0 && prev === 1'b1)
					n++;
				prev = sclf;
			end
		join
		chk(n[7:0], 8'h05);
		// Master clock widths, same with filter off and on
		set_ctl(8'h00);
		en <= 1'b0;
		wr(`LCFG_ADDR_CLK_LOW, 8'h02);
		wr(`LCFG_ADDR_CLK_HIGH, 8'h03);
		rd(`LCFG_ADDR_CLK_HIGH, 8'h03);
		for (int i = 0; i < 2; i++) begin
			set_ctl(i ? 8'h0C : 8'h08);
			@(posedge clk);
			run <= 1'b1;
			n = 0;
			while (mlow !== 1'b1 && n < 20) begin
				step();
				n++;
			end
			lo = 0;
			while (mlow === 1'b1 && lo < 300) begin
				step();
				lo++;
			end
			chk({7'h00, scl_ln}, 8'h00);
			hi = 0;
			while (mlow === 1'b0 && hi < 300) begin
				step();
				hi++;
			end
			chk(lo[7:0], 8'h02);
			chk(hi[7:0], 8'h03);
			@(posedge clk);
			run <= 1'b0;
		end
		stop_test();
	end
endmodule // test_lcfg_top
